// File: clock_source_defines.svh
// Constants shared by the clock source control block.
`ifndef CLOCK_SOURCE_DEFINES_SVH
`define CLOCK_SOURCE_DEFINES_SVH

// ==========================================================================
// Register offsets.
`define CSC_ADDR_W 4
`define CSC_CTRL_ADDR 4'h0
`define CSC_BACKUP_ADDR 4'h1
`define CSC_SEL_ADDR 4'h2
`define CSC_STAT_ADDR 4'h3
`define CSC_IRQ_STAT_ADDR 4'h4
`define CSC_IRQ_MASK_ADDR 4'h5

// ==========================================================================
// Control register bit positions.
`define CSC_FI_ON 0
`define CSC_FI_RDY 1
`define CSC_FE_ON 16
`define CSC_FE_RDY 17
`define CSC_FE_BYP 18
`define CSC_PLL_ON 24
`define CSC_PLL_RDY 25
`define CSC_SI_ON 4
`define CSC_SI_RDY 5
`define CSC_SI_STOP 6

// Backup control register bit positions.
`define CSC_SE_ON 0
`define CSC_SE_RDY 1
`define CSC_SE_BYP 2

// ==========================================================================
// Interrupt bits: one per ready flag, plus switch done.
`define CSC_IRQ_W 6
`define CSC_IRQ_FI 0
`define CSC_IRQ_FE 1
`define CSC_IRQ_PLL 2
`define CSC_IRQ_SI 3
`define CSC_IRQ_SE 4
`define CSC_IRQ_SW 5

// ==========================================================================
// Timing and division.
`define CSC_SI_DIV 256
`define CSC_FE_STARTUP_CYC 16'h0800
`define CSC_SE_STARTUP_CYC 16'h1000
`define CSC_PLL_LOCK_CYC 16'h0100
`define CSC_FI_STARTUP_CYC 16'h0008
`define CSC_BYP_STARTUP_CYC 16'h0004
`define CSC_HANDOVER_CYC 3'h3

`endif

// File: clock_source_pkg.sv
// Types shared by the clock source control block.
package clock_source_pkg;

	typedef enum logic [1:0] {
		SRC_FAST_INT = 2'h0,
		SRC_FAST_EXT = 2'h1,
		SRC_PLL = 2'h2,
		SRC_FABRIC = 2'h3
	} sys_src_t;

	typedef enum logic [1:0] {
		SW_IDLE,
		SW_WAIT_READY,
		SW_HANDOVER
	} switch_state_t;

endpackage

// File: osc_ready_timer.sv
// Startup timer that raises a ready flag after an oscillator settles.
`timescale 1ns/100ps
`include "clock_source_defines.svh"

module osc_ready_timer #(
	parameter int CNT_W = 16
) (
	input wire logic i_ref_clk,
	input wire logic i_reset_n,
	input wire logic i_enable,
	input wire logic [CNT_W-1:0] i_delay,
	output logic o_ready
);

	logic [CNT_W-1:0] count_q;

	// A drop of the enable clears the flag on the next clock edge, so a stopped
	// oscillator looks ready for at most one cycle.
	always_ff @(posedge i_ref_clk) begin
		if (!i_reset_n || !i_enable) begin
			count_q <= '0;
			o_ready <= 1'b0;
		end else if (!o_ready) begin
			if (count_q >= i_delay - {{(CNT_W-1){1'b0}}, 1'b1}) begin
				o_ready <= 1'b1;
			end
			count_q <= count_q + {{(CNT_W-1){1'b0}}, 1'b1};
		end
	end

endmodule

// File: clock_source_ctrl.sv
// Clock source enables, ready tracking and system clock selection.
//
// The address-and-strobe port and the placing of the registers are this design's own decisions.
`timescale 1ns/100ps
`include "clock_source_defines.svh"

module clock_source_ctrl #(
	parameter logic [15:0] FE_STARTUP = `CSC_FE_STARTUP_CYC,
	parameter logic [15:0] SE_STARTUP = `CSC_SE_STARTUP_CYC,
	parameter logic [15:0] PLL_LOCK = `CSC_PLL_LOCK_CYC
) (
	input wire logic i_ref_clk,
	input wire logic i_reset_n,
	input wire logic [`CSC_ADDR_W-1:0] i_addr,
	input wire logic [31:0] i_wdata,
	input wire logic i_wr,
	input wire logic i_rd,
	input wire logic i_stop_mode,
	output logic [31:0] o_rdata,
	output logic o_irq,
	output logic o_fast_int_osc_en,
	output logic o_fast_ext_osc_en,
	output logic o_fast_ext_bypass,
	output logic o_fast_ext_clock_gate,
	output logic o_pll_en,
	output logic o_pll_ref_gate,
	output logic o_slow_int_clock_en,
	output logic o_slow_int_clock,
	output logic o_slow_ext_osc_en,
	output logic o_slow_ext_bypass,
	output logic o_slow_ext_clock_gate,
	output logic [1:0] o_sys_src,
	output logic o_switching
);

	// ======================================================================
	// Enable and bypass bits.
	logic fi_on_q;
	logic fe_on_q;
	logic fe_byp_q;
	logic pll_on_q;
	logic si_on_q;
	logic si_stop_q;
	logic se_on_q;
	logic se_byp_q;
	logic fi_rdy;
	logic fe_rdy;
	logic pll_rdy;
	logic si_rdy;
	logic se_rdy;
	logic [1:0] req_src_q;
	clock_source_pkg::sys_src_t cur_src_q;
	clock_source_pkg::switch_state_t sw_state_q;
	logic [2:0] hand_cnt_q;
	logic [`CSC_IRQ_W-1:0] irq_stat_q;
	logic [`CSC_IRQ_W-1:0] irq_mask_q;
	logic [`CSC_IRQ_W-1:0] rdy_vec;
	logic [`CSC_IRQ_W-1:0] rdy_prev_q;
	logic sw_done;
	logic fe_in_use;
	logic fi_in_use;
	logic pll_in_use;
	logic wr_ctrl;
	logic wr_bkp;
	logic [7:0] div_q;
	logic si_run;

	assign wr_ctrl = i_wr && (i_addr == `CSC_CTRL_ADDR);
	assign wr_bkp = i_wr && (i_addr == `CSC_BACKUP_ADDR);

	// A source counts as in use while it feeds the clock now or is the target
	// of a pending switch, so neither end of a handover can be pulled away.
	assign fi_in_use = (cur_src_q == clock_source_pkg::SRC_FAST_INT)
		|| (sw_state_q != clock_source_pkg::SW_IDLE
		&& req_src_q == clock_source_pkg::SRC_FAST_INT);
	assign pll_in_use = (cur_src_q == clock_source_pkg::SRC_PLL)
		|| (sw_state_q != clock_source_pkg::SW_IDLE
		&& req_src_q == clock_source_pkg::SRC_PLL);
	assign fe_in_use = (cur_src_q == clock_source_pkg::SRC_FAST_EXT)
		|| (sw_state_q != clock_source_pkg::SW_IDLE
		&& req_src_q == clock_source_pkg::SRC_FAST_EXT)
		|| pll_in_use;

	// ======================================================================
	// Control register writes. Clearing an enable of a source in use is
	// ignored; each source has its own bit.
	always_ff @(posedge i_ref_clk) begin
		if (!i_reset_n) begin
			fi_on_q <= 1'b1;
			fe_on_q <= 1'b0;
			fe_byp_q <= 1'b0;
			pll_on_q <= 1'b0;
			si_on_q <= 1'b0;
			si_stop_q <= 1'b0;
		end else if (wr_ctrl) begin
			fi_on_q <= i_wdata[`CSC_FI_ON] || fi_in_use;
			fe_on_q <= i_wdata[`CSC_FE_ON] || fe_in_use;
			pll_on_q <= i_wdata[`CSC_PLL_ON] || pll_in_use;
			si_on_q <= i_wdata[`CSC_SI_ON];
			si_stop_q <= i_wdata[`CSC_SI_STOP];
			// Bypass may change only while the fast external source is off.
			if (!fe_on_q) begin
				fe_byp_q <= i_wdata[`CSC_FE_BYP];
			end
		end
	end

	always_ff @(posedge i_ref_clk) begin
		if (!i_reset_n) begin
			se_on_q <= 1'b0;
			se_byp_q <= 1'b0;
		end else if (wr_bkp) begin
			se_on_q <= i_wdata[`CSC_SE_ON];
			if (!se_on_q) begin
				se_byp_q <= i_wdata[`CSC_SE_BYP];
			end
		end
	end

	// ======================================================================
	// Ready timers. The loop can only lock once its reference is ready.
	osc_ready_timer u_fi_rdy (
		.i_ref_clk(i_ref_clk),
		.i_reset_n(i_reset_n),
		.i_enable(fi_on_q),
		.i_delay(`CSC_FI_STARTUP_CYC),
		.o_ready(fi_rdy)
	);

	osc_ready_timer u_fe_rdy (
		.i_ref_clk(i_ref_clk),
		.i_reset_n(i_reset_n),
		.i_enable(fe_on_q),
		.i_delay(fe_byp_q ? `CSC_BYP_STARTUP_CYC : FE_STARTUP),
		.o_ready(fe_rdy)
	);

	osc_ready_timer u_pll_rdy (
		.i_ref_clk(i_ref_clk),
		.i_reset_n(i_reset_n),
		.i_enable(pll_on_q && fe_rdy),
		.i_delay(PLL_LOCK),
		.o_ready(pll_rdy)
	);

	osc_ready_timer u_se_rdy (
		.i_ref_clk(i_ref_clk),
		.i_reset_n(i_reset_n),
		.i_enable(se_on_q),
		.i_delay(se_byp_q ? `CSC_BYP_STARTUP_CYC : SE_STARTUP),
		.o_ready(se_rdy)
	);

	// ======================================================================
	// Slow internal clock: fast internal divided by 256. It keeps running in
	// Stop mode only when the stop-run bit allows it.
	assign si_run = si_on_q && fi_rdy && (!i_stop_mode || si_stop_q);
	assign si_rdy = si_on_q && fi_rdy;

	always_ff @(posedge i_ref_clk) begin
		if (!i_reset_n || !si_run) begin
			div_q <= 8'h00;
		end else begin
			div_q <= div_q + 8'h01;
		end
	end

	always_ff @(posedge i_ref_clk) begin
		if (!i_reset_n) begin
			o_slow_int_clock <= 1'b0;
			o_slow_int_clock_en <= 1'b0;
		end else begin
			o_slow_int_clock <= si_run && div_q[7];
			o_slow_int_clock_en <= si_run;
		end
	end

	// ======================================================================
	// System clock switch. A request waits for the target to be ready, then
	// both sources overlap for a few cycles before the mux moves.
	always_ff @(posedge i_ref_clk) begin
		if (!i_reset_n) begin
			req_src_q <= clock_source_pkg::SRC_FAST_INT;
			cur_src_q <= clock_source_pkg::SRC_FAST_INT;
			sw_state_q <= clock_source_pkg::SW_IDLE;
			hand_cnt_q <= 3'h0;
		end else begin
			unique case (sw_state_q)
				clock_source_pkg::SW_IDLE: begin
					if (i_wr && i_addr == `CSC_SEL_ADDR
						&& i_wdata[1:0] != cur_src_q) begin
						req_src_q <= i_wdata[1:0];
						sw_state_q <= clock_source_pkg::SW_WAIT_READY;
					end
				end
				clock_source_pkg::SW_WAIT_READY: begin
					if (i_wr && i_addr == `CSC_SEL_ADDR) begin
						req_src_q <= i_wdata[1:0];
						if (i_wdata[1:0] == cur_src_q) begin
							sw_state_q <= clock_source_pkg::SW_IDLE;
						end
					end else if (target_ready(req_src_q)) begin
						hand_cnt_q <= 3'h0;
						sw_state_q <= clock_source_pkg::SW_HANDOVER;
					end
				end
				clock_source_pkg::SW_HANDOVER: begin
					if (!target_ready(req_src_q)) begin
						sw_state_q <= clock_source_pkg::SW_WAIT_READY;
					end else if (hand_cnt_q == `CSC_HANDOVER_CYC) begin
						cur_src_q <= clock_source_pkg::sys_src_t'(req_src_q);
						sw_state_q <= clock_source_pkg::SW_IDLE;
					end else begin
						hand_cnt_q <= hand_cnt_q + 3'h1;
					end
				end
			endcase
		end
	end

	assign sw_done = (sw_state_q == clock_source_pkg::SW_HANDOVER)
		&& target_ready(req_src_q) && (hand_cnt_q == `CSC_HANDOVER_CYC);

	function automatic logic target_ready(input logic [1:0] src);
		unique case (src)
			clock_source_pkg::SRC_FAST_INT: target_ready = fi_rdy;
			clock_source_pkg::SRC_FAST_EXT: target_ready = fe_rdy;
			clock_source_pkg::SRC_PLL: target_ready = pll_rdy;
			default: target_ready = 1'b1;
		endcase
	endfunction

	// ======================================================================
	// Interrupts: rising ready flags and completed switches are sticky.
	assign rdy_vec = {sw_done, se_rdy, si_rdy, pll_rdy, fe_rdy, fi_rdy};

	always_ff @(posedge i_ref_clk) begin
		if (!i_reset_n) begin
			rdy_prev_q <= '0;
			irq_stat_q <= '0;
			irq_mask_q <= '0;
		end else begin
			rdy_prev_q <= rdy_vec;
			// A new event wins over a write-one clear in the same cycle.
			irq_stat_q <= (irq_stat_q & ~((i_wr && i_addr == `CSC_IRQ_STAT_ADDR)
				? i_wdata[`CSC_IRQ_W-1:0] : '0))
				| (rdy_vec & ~rdy_prev_q);
			if (i_wr && i_addr == `CSC_IRQ_MASK_ADDR) begin
				irq_mask_q <= i_wdata[`CSC_IRQ_W-1:0];
			end
		end
	end

	// ======================================================================
	// Read port, answering one cycle after the strobe. Ready flags have no
	// write path.
	always_ff @(posedge i_ref_clk) begin
		if (!i_reset_n) begin
			o_rdata <= 32'h00000000;
		end else if (i_rd) begin
			o_rdata <= 32'h00000000;
			unique case (i_addr)
				`CSC_CTRL_ADDR: begin
					o_rdata[`CSC_FI_ON] <= fi_on_q;
					o_rdata[`CSC_FI_RDY] <= fi_rdy;
					o_rdata[`CSC_FE_ON] <= fe_on_q;
					o_rdata[`CSC_FE_RDY] <= fe_rdy;
					o_rdata[`CSC_FE_BYP] <= fe_byp_q;
					o_rdata[`CSC_PLL_ON] <= pll_on_q;
					o_rdata[`CSC_PLL_RDY] <= pll_rdy;
					o_rdata[`CSC_SI_ON] <= si_on_q;
					o_rdata[`CSC_SI_RDY] <= si_rdy;
					o_rdata[`CSC_SI_STOP] <= si_stop_q;
				end
				`CSC_BACKUP_ADDR: begin
					o_rdata[`CSC_SE_ON] <= se_on_q;
					o_rdata[`CSC_SE_RDY] <= se_rdy;
					o_rdata[`CSC_SE_BYP] <= se_byp_q;
				end
				`CSC_SEL_ADDR: o_rdata[3:0] <= {cur_src_q, req_src_q};
				`CSC_STAT_ADDR: o_rdata[1:0] <= {i_stop_mode,
					sw_state_q != clock_source_pkg::SW_IDLE};
				`CSC_IRQ_STAT_ADDR: o_rdata[`CSC_IRQ_W-1:0] <= irq_stat_q;
				`CSC_IRQ_MASK_ADDR: o_rdata[`CSC_IRQ_W-1:0] <= irq_mask_q;
				default: o_rdata <= 32'h00000000;
			endcase
		end else begin
			o_rdata <= 32'h00000000;
		end
	end

	// ======================================================================
	// Registered outputs toward the analog cells and the clock mux.
	always_ff @(posedge i_ref_clk) begin
		if (!i_reset_n) begin
			o_irq <= 1'b0;
			o_fast_int_osc_en <= 1'b1;
			o_fast_ext_osc_en <= 1'b0;
			o_fast_ext_bypass <= 1'b0;
			o_fast_ext_clock_gate <= 1'b0;
			o_pll_en <= 1'b0;
			o_pll_ref_gate <= 1'b0;
			o_slow_ext_osc_en <= 1'b0;
			o_slow_ext_bypass <= 1'b0;
			o_slow_ext_clock_gate <= 1'b0;
			o_sys_src <= clock_source_pkg::SRC_FAST_INT;
			o_switching <= 1'b0;
		end else begin
			o_irq <= |(irq_stat_q & irq_mask_q);
			o_fast_int_osc_en <= fi_on_q;
			o_fast_ext_osc_en <= fe_on_q && !fe_byp_q;
			o_fast_ext_bypass <= fe_on_q && fe_byp_q;
			o_fast_ext_clock_gate <= fe_rdy;
			o_pll_en <= pll_on_q;
			o_pll_ref_gate <= pll_on_q && fe_rdy;
			o_slow_ext_osc_en <= se_on_q && !se_byp_q;
			o_slow_ext_bypass <= se_on_q && se_byp_q;
			o_slow_ext_clock_gate <= se_rdy;
			o_sys_src <= cur_src_q;
			o_switching <= sw_state_q != clock_source_pkg::SW_IDLE;
		end
	end

endmodule

// File: osc_partner.sv
// Behavioural oscillator or bypass clock standing at the far side of a gate.
`timescale 1ns/100ps

module osc_partner #(
	parameter realtime HALF_NS = 62.5
) (
	input wire logic i_run,
	input wire logic i_gate,
	output logic o_rel_clk
);
	logic osc_q = 1'b0;
	// A stopped source rests low, so a frozen gate cannot hide a late edge.
	always #(HALF_NS) osc_q = i_run ? ~osc_q : 1'b0;
	assign o_rel_clk = osc_q & i_gate;
endmodule

// File: system_clock_source_control_asserts.sv
// Concurrent checks on the clock source control ports.
`timescale 1ns/100ps

module system_clock_source_control_asserts (
	input wire logic i_ref_clk,
	input wire logic i_reset_n,
	input wire logic o_fast_int_osc_en,
	input wire logic o_fast_ext_osc_en,
	input wire logic o_fast_ext_bypass,
	input wire logic o_fast_ext_clock_gate,
	input wire logic o_pll_en,
	input wire logic o_slow_ext_osc_en,
	input wire logic o_slow_ext_bypass,
	input wire logic o_slow_ext_clock_gate,
	input wire logic o_slow_int_clock_en,
	input wire logic o_slow_int_clock,
	input wire logic [1:0] o_sys_src,
	input wire logic o_switching
);
	default clocking cb @(posedge i_ref_clk); endclocking
	default disable iff (!i_reset_n);
	// ==================================================================
	// Divider half-period tracking.
	logic prev_q;
	logic valid_q;
	logic [7:0] cnt_q;
	always_ff @(posedge i_ref_clk) begin
		if (!i_reset_n) begin
			prev_q <= 1'b0;
			valid_q <= 1'b0;
			cnt_q <= 8'h00;
		end else begin
			prev_q <= o_slow_int_clock;
			cnt_q <= (prev_q != o_slow_int_clock) ? 8'h00 : cnt_q + 8'h01;
			valid_q <= o_slow_int_clock_en &&
				(valid_q || prev_q != o_slow_int_clock);
		end
	end
	// ==================================================================
	// Properties.
	property p_reset;
		$rose(i_reset_n) |-> o_sys_src == 2'h0 && o_fast_int_osc_en
			&& !o_fast_ext_osc_en && !o_pll_en && !o_switching;
	endproperty
	a_reset: assert property (p_reset) else $error("reset state wrong");
	property p_fe_byp;
		o_fast_ext_bypass |-> !o_fast_ext_osc_en;
	endproperty
	a_fe_byp: assert property (p_fe_byp) else $error("bypass with driver");
	property p_fe_gate;
		$rose(o_fast_ext_clock_gate) |-> $past(o_fast_ext_osc_en
			|| o_fast_ext_bypass) && $past(o_fast_ext_osc_en || o_fast_ext_bypass, 3);
	endproperty
	a_fe_gate: assert property (p_fe_gate) else $error("fast gate early");
	property p_se_gate;
		$rose(o_slow_ext_clock_gate) |-> $past(o_slow_ext_osc_en
			|| o_slow_ext_bypass) && $past(o_slow_ext_osc_en || o_slow_ext_bypass, 3);
	endproperty
	a_se_gate: assert property (p_se_gate) else $error("slow gate early");
	property p_fe_busy;
		o_sys_src == clock_source_pkg::SRC_FAST_EXT |->
			o_fast_ext_osc_en || o_fast_ext_bypass;
	endproperty
	a_fe_busy: assert property (p_fe_busy) else $error("used source off");
	property p_pll_busy;
		o_sys_src == clock_source_pkg::SRC_PLL |-> o_pll_en
			&& (o_fast_ext_osc_en || o_fast_ext_bypass);
	endproperty
	a_pll_busy: assert property (p_pll_busy) else $error("loop chain off");
	property p_ready_sw;
		$changed(o_sys_src) && o_sys_src == clock_source_pkg::SRC_FAST_EXT
			|-> $past(o_fast_ext_clock_gate);
	endproperty
	a_ready_sw: assert property (p_ready_sw) else $error("switch not ready");
	property p_handover;
		$changed(o_sys_src) |-> $past(o_switching, 2);
	endproperty
	a_handover: assert property (p_handover) else $error("abrupt switch");
	property p_div;
		o_slow_int_clock != prev_q && valid_q && o_slow_int_clock_en
			|-> cnt_q == 8'h7F;
	endproperty
	a_div: assert property (p_div) else $error("divider period wrong");
endmodule

// File: system_clock_source_control_bench.sv
// Self-checking bench for the clock source control block.
`timescale 1ns/100ps
`include "clock_source_defines.svh"

module system_clock_source_control_bench;
	localparam logic [31:0] FI = 32'h3, FE = 32'h1 << `CSC_FE_ON;
	localparam logic [31:0] FER = 32'h1 << `CSC_FE_RDY, BYP = 32'h1 << `CSC_FE_BYP;
	localparam logic [31:0] PL = 32'h1 << `CSC_PLL_ON, SI = 32'h1 << `CSC_SI_ON;
	localparam logic [31:0] SIS = 32'h1 << `CSC_SI_STOP;
	logic i_ref_clk = 1'b0, i_reset_n = 1'b0, i_wr = 1'b0, i_rd = 1'b0;
	logic i_stop_mode = 1'b0;
	logic [3:0] i_addr = 4'h0;
	logic [31:0] i_wdata = 32'h0, o_rdata;
	logic o_irq, o_fast_int_osc_en, o_fast_ext_osc_en, o_fast_ext_bypass;
	logic o_fast_ext_clock_gate, o_pll_en, o_pll_ref_gate, o_slow_int_clock_en;
	logic o_slow_int_clock, o_slow_ext_osc_en, o_slow_ext_bypass;
	logic o_slow_ext_clock_gate, o_switching, fe_rel, se_rel;
	logic [1:0] o_sys_src;
	int err_total = 0, n_checks = 0, cyc = 0, fe_edges = 0, se_edges = 0;
	always #50 i_ref_clk = ~i_ref_clk;
	clock_source_ctrl #(.FE_STARTUP(16'h0010), .SE_STARTUP(16'h0010),
		.PLL_LOCK(16'h0010)) uut (.i_ref_clk(i_ref_clk), .i_reset_n(i_reset_n),
		.i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
		.i_stop_mode(i_stop_mode), .o_rdata(o_rdata), .o_irq(o_irq),
		.o_fast_int_osc_en(o_fast_int_osc_en), .o_fast_ext_osc_en(o_fast_ext_osc_en),
		.o_fast_ext_bypass(o_fast_ext_bypass), .o_pll_en(o_pll_en),
		.o_fast_ext_clock_gate(o_fast_ext_clock_gate), .o_pll_ref_gate(o_pll_ref_gate),
		.o_slow_int_clock_en(o_slow_int_clock_en), .o_slow_int_clock(o_slow_int_clock),
		.o_slow_ext_osc_en(o_slow_ext_osc_en), .o_slow_ext_bypass(o_slow_ext_bypass),
		.o_slow_ext_clock_gate(o_slow_ext_clock_gate), .o_sys_src(o_sys_src),
		.o_switching(o_switching));
	// The fast partner runs at the worst-case bypass rate of 100 MHz.
	osc_partner #(.HALF_NS(5.0)) fe_src (.i_run(o_fast_ext_osc_en | o_fast_ext_bypass),
		.i_gate(o_fast_ext_clock_gate), .o_rel_clk(fe_rel));
	osc_partner #(.HALF_NS(500.0)) se_src (.i_run(o_slow_ext_osc_en | o_slow_ext_bypass),
		.i_gate(o_slow_ext_clock_gate), .o_rel_clk(se_rel));
	always @(posedge fe_rel) fe_edges++;
	always @(posedge se_rel) se_edges++;
	// ==================================================================
	// Shared tasks.
	task chk(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			err_total++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task wr(input logic [3:0] a, input logic [31:0] d);
		@(posedge i_ref_clk);
		i_wr <= 1'b1;
		i_addr <= a;
		i_wdata <= d;
		@(posedge i_ref_clk);
		i_wr <= 1'b0;
	endtask
	task rd(input logic [3:0] a, input logic [31:0] exp);
		@(posedge i_ref_clk);
		i_rd <= 1'b1;
		i_addr <= a;
		@(posedge i_ref_clk);
		i_rd <= 1'b0;
		#1;
		chk(o_rdata, exp);
	endtask
	task cy(input int n);
		repeat (n) @(posedge i_ref_clk);
		#1;
	endtask
	task wait_src(input logic [1:0] s);
		for (int i = 0; i < 80 && o_sys_src !== s; i++) cy(1);
		chk({30'h0, o_sys_src}, {30'h0, s});
	endtask
	task end_of_test;
		$display("checks=%0d errors=%0d", n_checks, err_total);
		if (err_total == 0 && n_checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	// ==================================================================
	// Scenarios.
	task t_fast_ext;
		wr(`CSC_CTRL_ADDR, FI | FE);
		cy(8);
		chk({o_fast_ext_osc_en, o_fast_ext_clock_gate}, 2'b10);
		chk(fe_edges, 0);
		cy(40);
		chk(fe_edges != 0 && o_fast_ext_clock_gate === 1'b1, 1);
		rd(`CSC_CTRL_ADDR, FI | FE | FER);
		wr(`CSC_SEL_ADDR, 32'h1);
		wait_src(2'h1);
		rd(`CSC_SEL_ADDR, 32'h5);
		wr(`CSC_CTRL_ADDR, FI);
		cy(3);
		chk(o_fast_ext_osc_en, 1'b1);
	endtask
	task t_pll;
		wr(`CSC_SEL_ADDR, 32'h2);
		cy(60);
		chk({o_sys_src, o_switching}, 3'b011);
		rd(`CSC_STAT_ADDR, 32'h1);
		// The loop is assumed programmed for a 48 MHz output here.
		wr(`CSC_CTRL_ADDR, FI | FE | PL);
		wait_src(2'h2);
		chk(o_pll_ref_gate, 1'b1);
		wr(`CSC_CTRL_ADDR, FI);
		cy(3);
		chk({o_pll_en, o_fast_ext_osc_en}, 2'b11);
		wr(`CSC_SEL_ADDR, 32'h3);
		wait_src(2'h3);
		wr(`CSC_SEL_ADDR, 32'h0);
		wait_src(2'h0);
		wr(`CSC_CTRL_ADDR, FI);
		cy(3);
		chk({o_pll_en, o_fast_ext_osc_en}, 2'b00);
		rd(`CSC_CTRL_ADDR, FI);
	endtask
	task t_bypass;
		wr(`CSC_CTRL_ADDR, FI | BYP);
		wr(`CSC_CTRL_ADDR, FI | BYP | FE);
		cy(2);
		chk({o_fast_ext_bypass, o_fast_ext_osc_en}, 2'b10);
		cy(20);
		chk(o_fast_ext_clock_gate, 1'b1);
		wr(`CSC_CTRL_ADDR, FI | BYP);
		wr(`CSC_CTRL_ADDR, FI);
		cy(3);
		chk({o_fast_ext_bypass, o_fast_ext_clock_gate}, 2'b00);
	endtask
	task t_slow_ext_irq;
		wr(`CSC_IRQ_STAT_ADDR, 32'h3F);
		wr(`CSC_IRQ_MASK_ADDR, 32'h10);
		rd(`CSC_IRQ_MASK_ADDR, 32'h10);
		wr(`CSC_BACKUP_ADDR, 32'h1);
		cy(8);
		chk({o_slow_ext_osc_en, o_slow_ext_clock_gate, o_irq}, 3'b100);
		chk(se_edges, 0);
		cy(40);
		chk({o_slow_ext_clock_gate, o_irq}, 2'b11);
		rd(`CSC_BACKUP_ADDR, 32'h3);
		wr(`CSC_IRQ_MASK_ADDR, 32'h0);
		cy(2);
		chk(o_irq, 1'b0);
		wr(`CSC_IRQ_MASK_ADDR, 32'h10);
		cy(2);
		chk(o_irq, 1'b1);
		wr(`CSC_IRQ_STAT_ADDR, 32'h10);
		cy(2);
		chk(o_irq, 1'b0);
		rd(`CSC_IRQ_STAT_ADDR, 32'h0);
		rd(4'hF, 32'h0);
		wr(`CSC_BACKUP_ADDR, 32'h0);
		wr(`CSC_BACKUP_ADDR, 32'h4);
		wr(`CSC_BACKUP_ADDR, 32'h5);
		cy(2);
		chk({o_slow_ext_bypass, o_slow_ext_osc_en}, 2'b10);
		cy(8);
		chk(o_slow_ext_clock_gate, 1'b1);
		wr(`CSC_BACKUP_ADDR, 32'h4);
		wr(`CSC_BACKUP_ADDR, 32'h0);
		cy(3);
		rd(`CSC_BACKUP_ADDR, 32'h0);
	endtask
	task t_slow_int;
		int n;
		wr(`CSC_CTRL_ADDR, FI | SI);
		for (n = 0; n < 300 && o_slow_int_clock !== 1'b1; n++) cy(1);
		for (n = 0; n < 300 && o_slow_int_clock !== 1'b0; n++) cy(1);
		for (n = 0; n < 300 && o_slow_int_clock !== 1'b1; n++) cy(1);
		for (n = 0; n < 300 && o_slow_int_clock !== 1'b0; n++) cy(1);
		for (; n < 600 && o_slow_int_clock !== 1'b1; n++) cy(1);
		chk(n, 256);
		@(posedge i_ref_clk);
		i_stop_mode <= 1'b1;
		cy(3);
		chk(o_slow_int_clock_en, 1'b0);
		wr(`CSC_CTRL_ADDR, FI | SI | SIS);
		cy(3);
		chk(o_slow_int_clock_en, 1'b1);
		i_stop_mode <= 1'b0;
		wr(`CSC_CTRL_ADDR, FI);
		cy(3);
		chk(o_slow_int_clock_en, 1'b0);
	endtask
	task t_reset_mid;
		wr(`CSC_CTRL_ADDR, FI | FE);
		cy(40);
		wr(`CSC_SEL_ADDR, 32'h1);
		wait_src(2'h1);
		i_reset_n <= 1'b0;
		cy(2);
		i_reset_n <= 1'b1;
		cy(1);
		chk({o_sys_src, o_fast_int_osc_en, o_fast_ext_osc_en}, 4'h2);
	endtask
	// ==================================================================
	// Main sequence and hang guard.
	always @(posedge i_ref_clk) begin
		cyc++;
		if (cyc == 20000) begin
			err_total++;
			end_of_test();
		end
	end
	initial begin
		repeat (6) @(posedge i_ref_clk);
		i_reset_n <= 1'b1;
		cy(12);
		chk({o_sys_src, o_fast_int_osc_en, o_pll_en}, 4'h2);
		rd(`CSC_CTRL_ADDR, FI);
		t_fast_ext();
		t_pll();
		t_bypass();
		t_slow_ext_irq();
		t_slow_int();
		t_reset_mid();
		end_of_test();
	end
endmodule

bind clock_source_ctrl system_clock_source_control_asserts chk_u (
	.i_ref_clk(i_ref_clk), .i_reset_n(i_reset_n),
	.o_fast_int_osc_en(o_fast_int_osc_en), .o_fast_ext_osc_en(o_fast_ext_osc_en),
	.o_fast_ext_bypass(o_fast_ext_bypass), .o_pll_en(o_pll_en),
	.o_fast_ext_clock_gate(o_fast_ext_clock_gate),
	.o_slow_ext_osc_en(o_slow_ext_osc_en), .o_slow_int_clock(o_slow_int_clock),
	.o_slow_ext_bypass(o_slow_ext_bypass),
	.o_slow_ext_clock_gate(o_slow_ext_clock_gate), .o_sys_src(o_sys_src),
	.o_slow_int_clock_en(o_slow_int_clock_en), .o_switching(o_switching));
